// >>> rtl/legacy_fdl_byte_port.sv
`timescale 1ns/1ps
module legacy_fdl_byte_port
	import fdl_port_pkg::*;
(
	input wire logic SYS_CLK_I, // 50 MHz system clock
	input wire logic RST_I, // synchronous reset, active high
	input wire logic CYC_I, // wishbone cycle
	input wire logic STB_I, // wishbone strobe
	input wire logic WE_I, // wishbone write
	input wire logic [9:0] ADR_I, // wishbone byte address
	input wire logic [3:0] SEL_I, // wishbone byte lanes
	input wire logic [31:0] DAT_I, // wishbone write data
	output logic [31:0] DAT_O, // wishbone read data
	output logic ACK_O, // wishbone acknowledge
	input wire link_in_t [NCH-1:0] LINK_I, // framer bit strobes
	output logic [NCH-1:0] TX_BIT_O, // outgoing link or fs bit
	output logic [NCH-1:0] TX_OWN_O, // this block sources the link
	output logic INT_N_O // interrupt, active low
);

	// rotate right by one, so a byte repeats after eight bits
	function automatic logic [BW-1:0] rot8(input logic [BW-1:0] v);
		rot8 = {v[0], v[BW-1:1]};
	endfunction

	// ones counter step, saturating at six
	function automatic logic [2:0] ones_step(input logic [2:0] n, input logic b);
		ones_step = b ? ((n == ONES_SAT) ? ONES_SAT : n + 3'h1) : 3'h0;
	endfunction

	// register state, one copy per framer except the shared status and mask registers
	logic [BW-1:0] rxb_r [NCH], rxb_nxt [NCH]; // received byte
	logic [BW-1:0] m1_r [NCH], m1_nxt [NCH]; // match byte 1
	logic [BW-1:0] m2_r [NCH], m2_nxt [NCH]; // match byte 2
	logic [BW-1:0] txb_r [NCH], txb_nxt [NCH]; // host transmit byte
	logic [BW-1:0] ctl_r [NCH], ctl_nxt [NCH]; // control bits
	logic [STW-1:0] st_r, st_nxt; // sticky status flags
	logic [STW-1:0] mk_r, mk_nxt; // interrupt mask
	// receive path state
	logic [BW-1:0] rsh_r [NCH], rsh_nxt [NCH]; // receive shifter
	logic [2:0] rcnt_r [NCH], rcnt_nxt [NCH]; // bits collected
	logic [2:0] rone_r [NCH], rone_nxt [NCH]; // receive ones run
	// transmit path state
	logic [BW-1:0] tsh_r [NCH], tsh_nxt [NCH]; // transmit rotator
	logic [2:0] tcnt_r [NCH], tcnt_nxt [NCH]; // bits sent
	logic [2:0] tone_r [NCH], tone_nxt [NCH]; // transmit ones run
	logic [NCH-1:0] tbit_r, tbit_nxt; // outgoing bit
	logic [NCH-1:0] town_r, town_nxt; // source ownership
	// bus state
	logic ack_r, ack_nxt; // acknowledge
	logic [31:0] dat_r, dat_nxt; // read data
	logic int_n_r, int_n_nxt; // interrupt pin
	// decode helpers
	logic [7:0] idx; // register index
	logic req; // new bus request
	logic wr; // write strobe on lane 0
	logic [NCH-1:0] rx_take; // a bit enters the shifter
	logic [NCH-1:0] rx_done; // a byte completes
	logic [NCH-1:0] tx_stuff; // this slot sends a stuffed zero
	logic [NCH-1:0] tx_load; // host byte enters the rotator

	assign idx = ADR_I[9:2];
	assign req = CYC_I & STB_I & ~ack_r;
	assign wr = req & WE_I & SEL_I[0];

	// next state of the bus slave and all registers
	always_comb begin
		logic [STW-1:0] clr;
		logic [STW-1:0] set;
		logic [BW-1:0] rd;
		logic [BW-1:0] nb;
		clr = '0;
		set = '0;
		rd = REG_RST;
		nb = REG_RST;
		// single-cycle answer, unmapped indices read zero
		ack_nxt = req;
		mk_nxt = mk_r;
		if (wr && idx == IX_MASK) begin
			mk_nxt = DAT_I[STW-1:0];
		end
		if (wr && idx == IX_STAT) begin
			clr = DAT_I[STW-1:0]; // write one to clear
		end
		for (int c = 0; c < NCH; c++) begin
			m1_nxt[c] = m1_r[c];
			m2_nxt[c] = m2_r[c];
			txb_nxt[c] = txb_r[c];
			ctl_nxt[c] = ctl_r[c];
			rxb_nxt[c] = rxb_r[c];
			rsh_nxt[c] = rsh_r[c];
			rcnt_nxt[c] = rcnt_r[c];
			rone_nxt[c] = rone_r[c];
			tsh_nxt[c] = tsh_r[c];
			tcnt_nxt[c] = tcnt_r[c];
			tone_nxt[c] = tone_r[c];
			tbit_nxt[c] = tbit_r[c];
		end
		// framer A and framer B register writes
		if (wr) begin
			case (idx)
				IX_M1_A: m1_nxt[0] = DAT_I[BW-1:0];
				IX_M2_A: m2_nxt[0] = DAT_I[BW-1:0];
				IX_TXB_A: txb_nxt[0] = DAT_I[BW-1:0];
				IX_CTRL_A: ctl_nxt[0] = DAT_I[BW-1:0];
				IX_M1_B: m1_nxt[1] = DAT_I[BW-1:0];
				IX_M2_B: m2_nxt[1] = DAT_I[BW-1:0];
				IX_TXB_B: txb_nxt[1] = DAT_I[BW-1:0];
				IX_CTRL_B: ctl_nxt[1] = DAT_I[BW-1:0];
				default: ;
			endcase
		end
		// read multiplexer
		case (idx)
			IX_RXB_A: rd = rxb_r[0];
			IX_M1_A: rd = m1_r[0];
			IX_M2_A: rd = m2_r[0];
			IX_TXB_A: rd = txb_r[0];
			IX_CTRL_A: rd = ctl_r[0];
			IX_RXB_B: rd = rxb_r[1];
			IX_M1_B: rd = m1_r[1];
			IX_M2_B: rd = m2_r[1];
			IX_TXB_B: rd = txb_r[1];
			IX_CTRL_B: rd = ctl_r[1];
			IX_STAT: rd = st_r;
			IX_MASK: rd = mk_r;
			default: rd = REG_RST;
		endcase
		dat_nxt = (req && !WE_I) ? {24'h000000, rd} : 32'h00000000;
		for (int c = 0; c < NCH; c++) begin
			// receive: drop a zero after exactly five ones
			rx_take[c] = LINK_I[c].rx_slot & ~(ctl_r[c][CT_DESTUFF]
				& ~LINK_I[c].rx_bit & rone_r[c] == ONES_FIVE);
			rx_done[c] = rx_take[c] & (rcnt_r[c] == CNT_LAST);
			if (LINK_I[c].rx_slot) begin
				rone_nxt[c] = ones_step(rone_r[c], LINK_I[c].rx_bit);
			end
			if (rx_take[c]) begin
				nb = {LINK_I[c].rx_bit, rsh_r[c][BW-1:1]};
				rsh_nxt[c] = nb;
				rcnt_nxt[c] = rcnt_r[c] + 3'h1;
				if (rx_done[c]) begin
					rxb_nxt[c] = nb;
					set[c*ST_STRIDE+ST_FULL] = 1'b1;
					if (nb == m1_r[c] || nb == m2_r[c]) begin
						set[c*ST_STRIDE+ST_MATCH] = 1'b1;
					end
				end
			end
			// transmit: stuff a zero after five ones
			tx_stuff[c] = ctl_r[c][CT_STUFF] & (tone_r[c] == ONES_FIVE);
			tx_load[c] = (tcnt_r[c] == 3'h0) & ~tx_stuff[c]
				& (~ctl_r[c][CT_MFLOAD] | LINK_I[c].mf_bound);
			if (LINK_I[c].tx_slot) begin
				if (tx_stuff[c]) begin
					tbit_nxt[c] = 1'b0;
					tone_nxt[c] = 3'h0;
				end else begin
					nb = tx_load[c] ? txb_r[c] : tsh_r[c];
					tbit_nxt[c] = nb[0];
					tsh_nxt[c] = rot8(nb);
					tcnt_nxt[c] = tcnt_r[c] + 3'h1;
					tone_nxt[c] = ones_step(tone_r[c], nb[0]);
					if (tcnt_r[c] == CNT_LAST) begin
						set[c*ST_STRIDE+ST_EMPTY] = 1'b1;
					end
				end
			end
			// one source: off when fs comes from elsewhere in D4
			town_nxt[c] = ctl_r[c][CT_TX_EN]
				& ~(ctl_r[c][CT_D4] & ctl_r[c][CT_FS_SRC]);
		end
		// set wins over a clear in the same cycle
		st_nxt = (st_r & ~clr) | set;
		int_n_nxt = ~|(st_nxt & mk_nxt);
	end

	// register everything
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
			st_r <= '0;
			mk_r <= '0;
			int_n_r <= 1'b1;
			tbit_r <= '0;
			town_r <= '0;
			for (int c = 0; c < NCH; c++) begin
				rxb_r[c] <= REG_RST;
				m1_r[c] <= REG_RST;
				m2_r[c] <= REG_RST;
				txb_r[c] <= REG_RST;
				ctl_r[c] <= REG_RST;
				rsh_r[c] <= REG_RST;
				rcnt_r[c] <= 3'h0;
				rone_r[c] <= 3'h0;
				tsh_r[c] <= REG_RST;
				tcnt_r[c] <= 3'h0;
				tone_r[c] <= 3'h0;
			end
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			st_r <= st_nxt;
			mk_r <= mk_nxt;
			int_n_r <= int_n_nxt;
			tbit_r <= tbit_nxt;
			town_r <= town_nxt;
			for (int c = 0; c < NCH; c++) begin
				rxb_r[c] <= rxb_nxt[c];
				m1_r[c] <= m1_nxt[c];
				m2_r[c] <= m2_nxt[c];
				txb_r[c] <= txb_nxt[c];
				ctl_r[c] <= ctl_nxt[c];
				rsh_r[c] <= rsh_nxt[c];
				rcnt_r[c] <= rcnt_nxt[c];
				rone_r[c] <= rone_nxt[c];
				tsh_r[c] <= tsh_nxt[c];
				tcnt_r[c] <= tcnt_nxt[c];
				tone_r[c] <= tone_nxt[c];
			end
		end
	end

	assign DAT_O = dat_r;
	assign ACK_O = ack_r;
	assign TX_BIT_O = tbit_r;
	assign TX_OWN_O = town_r;
	assign INT_N_O = int_n_r;

	// checks: bus, framer A in depth, framer B spot checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	// bus: a taken request gets exactly one ack cycle
	a_ack_single: assert property (req
		|=> ACK_O ##1 !ACK_O)
		else $error("ack not a single pulse");
	// bus: no ack without a request taken the edge before
	a_ack_taken: assert property (!req
		|=> !ACK_O)
		else $error("ack without request");
	// bus: read data stands only in the ack cycle
	a_dat_idle: assert property (!ACK_O
		|-> DAT_O == 32'h00000000)
		else $error("read data outside ack");

	// receive: byte and full flag land together
	a_full_set: assert property (rx_done[0]
		|=> st_r[ST_FULL] && rxb_r[0] == $past(rsh_nxt[0]))
		else $error("full flag or byte wrong");
	// receive: last bit of a byte ends in the msb
	a_rx_lsb_first: assert property (rx_done[0]
		|=> rxb_r[0][BW-1] == $past(LINK_I[0].rx_bit))
		else $error("last received bit not in msb");
	// receive: earlier bits move one place toward the lsb
	a_rx_shift: assert property (rx_done[0]
		|=> rxb_r[0][BW-2:0] == $past(rsh_r[0][BW-1:1]))
		else $error("received bits out of order");
	// receive: the byte register moves only when a byte completes
	a_rx_hold: assert property (!rx_done[0]
		|=> $stable(rxb_r[0]))
		else $error("receive byte changed mid byte");
	// receive: no slot, no shift and no count
	a_slot_hold: assert property (!LINK_I[0].rx_slot
		|=> $stable(rcnt_r[0]) && $stable(rsh_r[0]))
		else $error("receive shifter moved without slot");
	// receive: full flag rises only with a completed byte
	a_full_quiet: assert property (!st_r[ST_FULL] && !rx_done[0]
		|=> !st_r[ST_FULL])
		else $error("full flag without byte");

	// destuff: a zero after exactly five ones is not counted
	a_destuff_drop: assert property (LINK_I[0].rx_slot && ctl_r[0][CT_DESTUFF]
		&& !LINK_I[0].rx_bit && rone_r[0] == ONES_FIVE
		|=> $stable(rcnt_r[0]))
		else $error("stuffed zero kept");
	// destuff off: every slot counts one bit
	a_destuff_off: assert property (LINK_I[0].rx_slot && !ctl_r[0][CT_DESTUFF]
		|=> rcnt_r[0] == $past(rcnt_r[0]) + 3'h1)
		else $error("bit lost with destuffer off");
	// destuff: after six or more ones the bit is counted
	a_six_ones_keep: assert property (LINK_I[0].rx_slot && rone_r[0] == ONES_SAT
		|=> rcnt_r[0] == $past(rcnt_r[0]) + 3'h1)
		else $error("zero after six ones dropped");

	// match: byte equal to match byte 1 raises the flag
	a_match_set: assert property (rx_done[0] && rsh_nxt[0] == m1_r[0]
		|=> st_r[ST_MATCH])
		else $error("match flag missed");
	// match: byte equal to match byte 2 raises the flag
	a_match2_set: assert property (rx_done[0] && rsh_nxt[0] == m2_r[0]
		|=> st_r[ST_MATCH])
		else $error("second match flag missed");
	// match: flag rises only with a completed byte
	a_match_quiet: assert property (!st_r[ST_MATCH] && !rx_done[0]
		|=> !st_r[ST_MATCH])
		else $error("match flag without byte");

	// stuff: the slot after five ones carries a zero
	a_tx_stuff: assert property (LINK_I[0].tx_slot && tx_stuff[0]
		|=> !TX_BIT_O[0])
		else $error("stuffed bit not zero");
	// stuff: a stuffed zero does not use up a byte position
	a_stuff_hold: assert property (LINK_I[0].tx_slot && tx_stuff[0]
		|=> $stable(tcnt_r[0]))
		else $error("stuffed zero counted as data");
	// transmit: a fresh byte starts with its lsb
	a_tx_load_lsb: assert property (LINK_I[0].tx_slot && tx_load[0]
		|=> TX_BIT_O[0] == $past(txb_r[0][0]))
		else $error("transmit byte not sent lsb first");
	// transmit: without a load the held byte keeps rotating out
	a_tx_repeat: assert property (LINK_I[0].tx_slot && !tx_load[0] && !tx_stuff[0]
		|=> TX_BIT_O[0] == $past(tsh_r[0][0]))
		else $error("held byte not resent");
	// transmit: the outgoing bit holds between slots
	a_tx_hold: assert property (!LINK_I[0].tx_slot
		|=> $stable(TX_BIT_O[0]))
		else $error("outgoing bit moved between slots");
	// transmit: eighth data bit raises the empty flag
	a_empty_set: assert property (LINK_I[0].tx_slot && !tx_stuff[0]
		&& tcnt_r[0] == CNT_LAST
		|=> st_r[ST_EMPTY])
		else $error("empty flag missed");
	// transmit: empty flag rises only after an eighth bit
	a_empty_quiet: assert property (!st_r[ST_EMPTY]
		&& !(LINK_I[0].tx_slot && !tx_stuff[0] && tcnt_r[0] == CNT_LAST)
		|=> !st_r[ST_EMPTY])
		else $error("empty flag without eighth bit");
	// multiframe load: no load off a boundary
	a_mf_wait: assert property (ctl_r[0][CT_MFLOAD] && !LINK_I[0].mf_bound
		|-> !tx_load[0])
		else $error("load off multiframe boundary");
	// ownership follows the control bits one cycle later
	a_own_level: assert property (TX_OWN_O[0]
		== $past(ctl_r[0][CT_TX_EN] & ~(ctl_r[0][CT_D4] & ctl_r[0][CT_FS_SRC])))
		else $error("link ownership wrong");

	// interrupt pin is low exactly while an enabled flag is set
	a_int_level: assert property (INT_N_O == !(|(st_r & mk_r)))
		else $error("interrupt level wrong");
	// flags: a set flag stays until written with a one
	a_flag_sticky: assert property (st_r[ST_FULL]
		&& !(wr && idx == IX_STAT && DAT_I[ST_FULL])
		|=> st_r[ST_FULL])
		else $error("flag dropped without clear");
	// flags: writing a one clears when no new byte completes
	a_clear_works: assert property (wr && idx == IX_STAT && DAT_I[ST_FULL]
		&& !rx_done[0]
		|=> !st_r[ST_FULL])
		else $error("flag not cleared");

	// framer B: its own full flag on its own byte
	a_b_full: assert property (rx_done[1]
		|=> st_r[ST_STRIDE+ST_FULL])
		else $error("framer B full flag missed");
	// framer B: its byte register ignores framer A traffic
	a_b_apart: assert property (!rx_done[1]
		|=> $stable(rxb_r[1]))
		else $error("framer B byte disturbed");
	// framer B: its own empty flag after its eighth bit
	a_b_empty: assert property (LINK_I[1].tx_slot && !tx_stuff[1]
		&& tcnt_r[1] == CNT_LAST
		|=> st_r[ST_STRIDE+ST_EMPTY])
		else $error("framer B empty flag missed");

	// main scenarios
	c_rx_byte: cover property (rx_done[0] ##1 st_r[ST_FULL]);
	c_match: cover property (rx_done[0] ##1 st_r[ST_MATCH]);
	c_stuffed: cover property (LINK_I[0].tx_slot && tx_stuff[0]);
	c_tx_repeat: cover property (st_r[ST_EMPTY] ##1 tx_load[0] && LINK_I[0].tx_slot);
	c_b_byte: cover property (rx_done[1] ##1 st_r[ST_STRIDE+ST_FULL]);

endmodule

// >>> rtl/fdl_port_pkg.sv
package fdl_port_pkg;
	// number of framers served, and byte width
	localparam int NCH = 2;
	localparam int BW = 8;
	// register index map; byte address is four times the index
	localparam logic [7:0] IX_RXB_A = 8'h28;
	localparam logic [7:0] IX_M1_A = 8'h29;
	localparam logic [7:0] IX_M2_A = 8'h2A;
	localparam logic [7:0] IX_TXB_A = 8'h7E;
	localparam logic [7:0] IX_RXB_B = 8'hC8;
	localparam logic [7:0] IX_M1_B = 8'hC9;
	localparam logic [7:0] IX_M2_B = 8'hCA;
	localparam logic [7:0] IX_TXB_B = 8'hFE;
	localparam logic [7:0] IX_CTRL_A = 8'h30;
	localparam logic [7:0] IX_CTRL_B = 8'h31;
	localparam logic [7:0] IX_STAT = 8'h32;
	localparam logic [7:0] IX_MASK = 8'h33;
	// control register fields
	localparam int CT_DESTUFF = 0;
	localparam int CT_FS_SRC = 2;
	localparam int CT_STUFF = 4;
	localparam int CT_MFLOAD = 5;
	localparam int CT_D4 = 6;
	localparam int CT_TX_EN = 7;
	// status and mask layout, one nibble per framer
	localparam int ST_FULL = 0;
	localparam int ST_MATCH = 1;
	localparam int ST_EMPTY = 2;
	localparam int ST_STRIDE = 4;
	localparam int STW = 8;
	// ones-run limits of the zero stuffer and destuffer, last bit count of a byte, register reset value
	localparam logic [2:0] ONES_FIVE = 3'h5;
	localparam logic [2:0] ONES_SAT = 3'h6;
	localparam logic [2:0] CNT_LAST = 3'h7;
	localparam logic [7:0] REG_RST = 8'h00;
	// per-framer bit strobes from the framer core
	typedef struct packed {
		logic rx_slot; // one received link bit is valid
		logic rx_bit; // received link or fs bit
		logic tx_slot; // framer takes the outgoing bit now
		logic mf_bound; // multiframe boundary pulse
	} link_in_t;
endpackage

// >>> tb/framer_model.sv
`timescale 1ns/1ps
module framer_model
	import fdl_port_pkg::*;
(
	input wire logic clk_i, // bit clock shared with the port
	input wire logic [NCH-1:0] tx_bit_i, // outgoing link bits
	output link_in_t [NCH-1:0] link_o // strobes toward the port
);
	logic [15:0] cap; // sampled outgoing bits, newest at msb
	// quiet strobes until a task runs
	initial begin
		link_o = '0;
		cap = 16'h0000;
	end
	// feed n received bits, first bit from the lsb
	task automatic rx(input int ch, input logic [15:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			link_o[ch].rx_slot <= 1'b1;
			link_o[ch].rx_bit <= v[i];
			@(posedge clk_i);
			link_o[ch].rx_slot <= 1'b0;
			link_o[ch].rx_bit <= ~v[i]; // line not held after the slot
		end
	endtask
	// issue n slots; each slot samples the bit chosen at the slot before
	task automatic tx(input int ch, input int n, input logic mf);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			cap <= {tx_bit_i[ch], cap[15:1]};
			link_o[ch].tx_slot <= 1'b1;
			link_o[ch].mf_bound <= mf && (i == n - 1);
			@(posedge clk_i);
			link_o[ch].tx_slot <= 1'b0;
			link_o[ch].mf_bound <= 1'b0;
		end
	endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import fdl_port_pkg::*;
;
	logic sys_clk, rst, cyc, stb, we; // clock, reset, bus strobes
	logic [9:0] adr; // bus byte address
	logic [3:0] sel; // bus lanes
	logic [31:0] dat, dat_o; // bus write and read data
	logic ack, int_n; // bus answer and interrupt
	logic [NCH-1:0] tx_bit, tx_own; // outgoing bits and ownership
	link_in_t [NCH-1:0] link; // strobes from the framer model
	logic [7:0] q; // last read value
	int bad_count, compares; // mismatches and comparisons
	legacy_fdl_byte_port DUT (.SYS_CLK_I(sys_clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
		.LINK_I(link), .TX_BIT_O(tx_bit), .TX_OWN_O(tx_own), .INT_N_O(int_n));
	framer_model fw (.clk_i(sys_clk), .tx_bit_i(tx_bit), .link_o(link));
	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// print the verdict and stop
	task automatic summarize();
		if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// compare seen against expected
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic bus cycle, held until ack is seen
	task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		dat <= {24'h000000, d};
		// ack and read data are sampled at the rising edge, released at that edge
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			summarize();
		end
	endtask
	// register write
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		wb(1'b1, ix, d, q);
	endtask
	// register read and compare
	task automatic rd(input logic [7:0] ix, input logic [7:0] e);
		wb(1'b0, ix, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask
	// hang guard, 100000 cycles
	initial begin
		#2000000;
		bad_count++;
		summarize();
	end
	// main sequence
	initial begin
		bad_count = 0;
		compares = 0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		sel = 4'hF;
		dat = 32'h00000000;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd(IX_STAT, 8'h00);
		chk({15'h0000, int_n}, 16'h0001);
		wr(IX_M1_A, 8'hA5);
		rd(IX_M1_A, 8'hA5);
		wr(IX_RXB_A, 8'h77);
		rd(IX_RXB_A, 8'h00);
		rd(8'h00, 8'h00);
		wr(IX_MASK, 8'h01);
		fw.rx(0, 16'h00A5, 8);
		rd(IX_RXB_A, 8'hA5);
		rd(IX_STAT, 8'h03);
		chk({15'h0000, int_n}, 16'h0000);
		wr(IX_STAT, 8'hFF);
		rd(IX_STAT, 8'h00);
		chk({15'h0000, int_n}, 16'h0001);
		wr(IX_CTRL_A, 8'h01);
		wr(IX_M2_A, 8'h7E);
		fw.rx(0, 16'h007E, 8);
		rd(IX_RXB_A, 8'h7E);
		rd(IX_STAT, 8'h03);
		wr(IX_STAT, 8'hFF);
		fw.rx(0, 16'h019F, 9);
		rd(IX_RXB_A, 8'hDF);
		fw.rx(1, 16'h003C, 8);
		rd(IX_RXB_B, 8'h3C);
		rd(IX_STAT, 8'h11);
		fw.rx(1, 16'h5AC3, 16);
		rd(IX_RXB_B, 8'h5A);
		rd(IX_STAT, 8'h11);
		wr(IX_STAT, 8'hFF);
		wr(IX_CTRL_A, 8'h80);
		wr(IX_TXB_A, 8'h1C);
		chk({14'h0000, tx_own}, 16'h0001);
		fw.tx(0, 9, 1'b0);
		chk({8'h00, fw.cap[15:8]}, 16'h001C);
		rd(IX_STAT, 8'h04);
		wr(IX_STAT, 8'hFF);
		wr(IX_CTRL_A, 8'h90);
		wr(IX_TXB_A, 8'h3F);
		fw.tx(0, 8, 1'b0);
		chk({8'h00, fw.cap[15:8]}, 16'h001C);
		fw.tx(0, 9, 1'b0);
		chk(fw.cap & 16'hFF80, 16'h2F80);
		wr(IX_CTRL_A, 8'hA0);
		wr(IX_TXB_A, 8'h55);
		fw.tx(0, 8, 1'b0);
		chk({8'h00, fw.cap[15:8]}, 16'h003F);
		fw.tx(0, 8, 1'b1);
		chk({8'h00, fw.cap[15:8]}, 16'h003F);
		fw.tx(0, 8, 1'b0);
		chk({8'h00, fw.cap[15:8]}, 16'h0055);
		wr(IX_CTRL_A, 8'hC4);
		rd(IX_TXB_A, 8'h55);
		chk({14'h0000, tx_own}, 16'h0000);
		wr(IX_CTRL_A, 8'hE0);
		rd(IX_CTRL_A, 8'hE0);
		chk({14'h0000, tx_own}, 16'h0001);
		summarize();
	end
endmodule
